// ==== test/erf_fetch_bench.sv ====
// Purpose: self-checking bench for erf_fetch
// Assumes: inputs driven at falling edge
// Notes: strap table in rows, fetch and timer by hand
`timescale 1ns/1ps
`define CHK(n, e, g) begin n_checks++; if ((g) !== (e)) begin n_mismatch++; \
   $display("MISMATCH %s exp %h got %h", n, e, g); end end
module erf_fetch_bench;
   logic sys_clk = 0, rst = 1, skip_active = 0, clock_pin_general_input = 0;
   logic clock_pin_halt_in = 0, halt_request = 0, host_bus_select = 1, dual_clock_select = 1;
   logic timer_source_select = 1, variant_select_high = 1, variant_select_low = 1;
   logic timer_event_in = 0, l_port_enable = 0;
   logic [10:0] program_counter = 11'h000;
   logic [7:0] l_port_data = 8'h00, fetch_bus_in, fetch_bus_out, instruction_byte, timer_count;
   logic [7:0] l_port_out, t0;
   logic fetch_bus_oe, addr_phase_strobe, skip_out, instruction_valid, cycle_tick;
   logic clock_pin_general_value, clock_pin_halt_out, clock_pin_halt_oe, host_bus_enable;
   logic dual_clock_enable, timer_enable, interrupt_enable, timer_overflow, l_port_oe;
   logic [6:0] ram_digit_limit;
   logic [1:0] stack_levels;
   logic [2:0] upper_rom_address, upper_address_mask;
   logic [18:0] rows [4];
   int n_mismatch = 0, n_checks = 0;
   always #2 sys_clk = ~sys_clk;
   erf_fetch i_erf_fetch (.*);
   erf_rom_model i_erf_rom_model (.strobe(addr_phase_strobe), .oe(fetch_bus_oe),
      .bus_out(fetch_bus_out), .upper(upper_rom_address), .mask(upper_address_mask),
      .bus_in(fetch_bus_in));
   task automatic complete_run;
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   // bounded wait for the fetch pulse; a hang ends the run
   task automatic wait_valid;
      for (int i = 0; i < 20; i++) begin
         @(posedge sys_clk); #1;
         if (instruction_valid === 1'b1) return;
      end
      n_mismatch++;
      complete_run();
   endtask
   task automatic fetch(input logic [10:0] pc, input logic [2:0] m, input logic sk);
      @(negedge sys_clk) begin program_counter = pc; skip_active = sk; end
      wait_valid();
      `CHK("address", pc, {upper_rom_address, fetch_bus_out})
      `CHK("skip", sk, skip_out)
      wait_valid();
      `CHK("byte", pc[7:0] ^ {pc[10:8] & m, 5'h15}, instruction_byte)
   endtask
   initial begin
      // {high, low, host, dual} then ram limit, stack, mask, host, dual, timer
      rows = '{{4'hD, 7'h7F, 2'h3, 3'h7, 3'h5}, {4'h6, 7'h3F, 2'h3, 3'h3, 3'h3},
         {4'h0, 7'h1F, 2'h2, 3'h1, 3'h0}, {4'h8, 7'h7F, 2'h3, 3'h7, 3'h7}};
      repeat (2) @(negedge sys_clk);
      rst = 0;
      foreach (rows[i]) begin
         @(negedge sys_clk);
         {variant_select_high, variant_select_low, host_bus_select,
            dual_clock_select} = rows[i][18:15];
         #1 `CHK("straps", rows[i][14:0], {ram_digit_limit, stack_levels, upper_address_mask,
            host_bus_enable, dual_clock_enable, timer_enable})
         `CHK("irq", rows[i][0], interrupt_enable)
      end
      $display("strap table done");
      {variant_select_high, variant_select_low} = 2'h3;
      fetch(11'h7FF, 3'h7, 1'b1);
      {variant_select_high, variant_select_low} = 2'h1;
      fetch(11'h5A3, 3'h3, 1'b0);
      {variant_select_high, variant_select_low} = 2'h0;
      fetch(11'h6C9, 3'h1, 1'b1);
      $display("fetch done");
      @(negedge sys_clk) {variant_select_high, variant_select_low, halt_request} = 3'h7;
      {l_port_enable, l_port_data, clock_pin_general_input} = {1'b1, 8'hA5, 1'b1};
      repeat (2) @(negedge sys_clk);
      `CHK("halt", 2'h2, {clock_pin_halt_oe, clock_pin_halt_out})
      `CHK("lport", 9'h1A5, {l_port_oe, l_port_out})
      `CHK("gin", 1'b1, clock_pin_general_value)
      t0 = timer_count;
      repeat (3) begin
         @(negedge sys_clk) timer_event_in = 1;
         repeat (2) @(negedge sys_clk);
         timer_event_in = 0;
      end
      @(negedge sys_clk) `CHK("events", t0 + 8'h03, timer_count)
      timer_source_select = 0;
      repeat (2) @(negedge sys_clk);
      t0 = timer_count;
      repeat (16) @(negedge sys_clk);
      `CHK("ticks", t0 + 8'h04, timer_count)
      // bounded wait for the wrap; 256 ticks fit in 1100 cycles
      for (int i = 0; i < 1100; i++) begin
         @(negedge sys_clk);
         if (timer_overflow === 1'b1) break;
      end
      `CHK("overflow", 9'h100, {timer_overflow, timer_count})
      // reset in mid run: state must return at once
      rst = 1;
      #1 `CHK("reset", 5'h10, {addr_phase_strobe, instruction_valid, upper_rom_address})
      @(negedge sys_clk) rst = 0;
      // first edge after release: still in address phase, reset address
      @(negedge sys_clk);
      `CHK("restart", 12'h800, {addr_phase_strobe, upper_rom_address, fetch_bus_out})
      wait_valid();
      `CHK("refetch", program_counter, {upper_rom_address, fetch_bus_out})
      $display("pins timer reset done");
      complete_run();
   end
endmodule

// ==== test/erf_rom_model.sv ====
// Purpose: external memory with low address latch
// Assumes: latch transparent while strobe high
// Notes: released bus shows inverse of latch, not a stale byte
`timescale 1ns/1ps
module erf_rom_model (
   input wire logic strobe,
   input wire logic oe,
   input wire logic [7:0] bus_out,
   input wire logic [2:0] upper,
   input wire logic [2:0] mask,
   output logic [7:0] bus_in
);
   logic [7:0] low_latch;
   logic [10:0] addr;
   // latch follows bus in address phase
   always_latch if (strobe) low_latch = bus_out;
   assign addr = {upper & mask, low_latch};
   // memory drives only once strobe drops
   always_comb begin
      if (oe) bus_in = bus_out;
      else if (!strobe) bus_in = addr[7:0] ^ {addr[10:8], 5'h15};
      else bus_in = ~low_latch;
   end
endmodule

// ==== test/erf_sva.sv ====
// Purpose: port checks on the fetch block
// Assumes: one clock, async high reset
// Notes: bound to erf_fetch below
`timescale 1ns/1ps
module erf_sva (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic [7:0] fetch_bus_in,
   input wire logic [7:0] fetch_bus_out,
   input wire logic fetch_bus_oe,
   input wire logic addr_phase_strobe,
   input wire logic [2:0] upper_rom_address,
   input wire logic [7:0] instruction_byte,
   input wire logic instruction_valid,
   input wire logic cycle_tick,
   input wire logic variant_select_high,
   input wire logic variant_select_low,
   input wire logic [1:0] stack_levels,
   input wire logic [7:0] timer_count,
   input wire logic timer_overflow
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);
   property p_oe; fetch_bus_oe == addr_phase_strobe; endproperty
   a_oe: assert property (p_oe) else $error("bus enable differs from strobe");
   property p_alen;
      $rose(addr_phase_strobe) |-> addr_phase_strobe[*4] ##1 !addr_phase_strobe;
   endproperty
   a_alen: assert property (p_alen) else $error("address phase length");
   property p_dlen;
      $fell(addr_phase_strobe) |-> !addr_phase_strobe[*4] ##1 addr_phase_strobe;
   endproperty
   a_dlen: assert property (p_dlen) else $error("data phase length");
   property p_valid; $rose(addr_phase_strobe) |-> instruction_valid; endproperty
   a_valid: assert property (p_valid) else $error("no byte after data phase");
   property p_byte; instruction_valid |-> instruction_byte == $past(fetch_bus_in); endproperty
   a_byte: assert property (p_byte) else $error("byte not from bus");
   property p_tick; cycle_tick |=> !cycle_tick[*3] ##1 cycle_tick; endproperty
   a_tick: assert property (p_tick) else $error("tick not one in four");
   property p_hold; addr_phase_strobe && $past(addr_phase_strobe)
      |-> $stable(fetch_bus_out) && $stable(upper_rom_address); endproperty
   a_hold: assert property (p_hold) else $error("address moved in phase");
   property p_stack; stack_levels == ((variant_select_high | variant_select_low) ? 2'h3 : 2'h2);
   endproperty
   a_stack: assert property (p_stack) else $error("stack depth wrong");
   // overflow pulse only as the count wraps to zero
   property p_ovf; timer_overflow |-> timer_count == 8'h00; endproperty
   a_ovf: assert property (p_ovf) else $error("overflow without wrap");
   c_ovf: cover property (timer_overflow);
   // main scenarios reached
   c_valid: cover property (instruction_valid);
   c_small: cover property (stack_levels == 2'h2);
   c_top: cover property (addr_phase_strobe && upper_rom_address == 3'h7);
endmodule
bind erf_fetch erf_sva i_erf_sva (.*);

// ==== verilog/erf_fetch.sv ====
// Purpose: external program fetch, clock divide and variant select straps
// Assumes: straps static; program counter and skip supplied by the core
// Notes: fetch bus is a two-way pin split into in, out and enable
`timescale 1ns/1ps
// Summary of operation
// - program address always spans full 2k words
// - strobe high: device drives low address byte
// - strobe low: device samples instruction byte in
// - top three address bits on own pins
// - skip indicator output for debug
// - internal timing is clock divided by four
// - separate general input and halt port pins
// - host bus port enabled when strap low, except in smallest variant
// - dual clock enabled when strap low, except in smallest variant
// - timer source internal low, events high
// - straps both one: full variant
// - upper zero lower one: half RAM
// - straps both zero: 32 digits, 4x8
// - smallest variant: stack depth two levels
// - L outputs may float under program control
// - no power-on init; reset input only
module erf_fetch (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic [10:0] program_counter,
   input wire logic skip_active,
   input wire logic [7:0] fetch_bus_in,
   output logic [7:0] fetch_bus_out,
   output logic fetch_bus_oe,
   output logic addr_phase_strobe,
   output logic [2:0] upper_rom_address,
   output logic skip_out,
   output logic [7:0] instruction_byte,
   output logic instruction_valid,
   output logic cycle_tick,
   input wire logic clock_pin_general_input,
   output logic clock_pin_general_value,
   input wire logic clock_pin_halt_in,
   output logic clock_pin_halt_out,
   output logic clock_pin_halt_oe,
   input wire logic halt_request,
   input wire logic host_bus_select,
   input wire logic dual_clock_select,
   input wire logic timer_source_select,
   input wire logic variant_select_high,
   input wire logic variant_select_low,
   output logic host_bus_enable,
   output logic dual_clock_enable,
   output logic timer_enable,
   output logic interrupt_enable,
   output logic [6:0] ram_digit_limit,
   output logic [1:0] stack_levels,
   output logic [2:0] upper_address_mask,
   input wire logic timer_event_in,
   output logic [7:0] timer_count,
   output logic timer_overflow,
   input wire logic [7:0] l_port_data,
   input wire logic l_port_enable,
   output logic [7:0] l_port_out,
   output logic l_port_oe
);
   typedef struct packed {
      logic [1:0] phase;
      erf_pkg::erf_fetch_type fetch;
      logic [10:0] address;
      logic [7:0] instr;
      logic valid;
      logic skip;
      logic [7:0] l_data;
      logic l_oe;
      logic halt_drive;
      logic general_value;
   } erf_state_type;
   erf_state_type state_reg;
   erf_state_type state_next;
   logic [1:0] variant_code;
   logic small_variant;

   // ----------------------------------------
   // variant decode
   // ----------------------------------------
   // decode the straps once; used by several outputs below
   function automatic logic [6:0] ram_limit_of(input logic [1:0] code);
      unique case (code)
         erf_pkg::ERF_SEL_FULL: ram_limit_of = erf_pkg::ERF_RAM_DIGITS_FULL;
         erf_pkg::ERF_SEL_HALF: ram_limit_of = erf_pkg::ERF_RAM_DIGITS_HALF;
         erf_pkg::ERF_SEL_SMALL: ram_limit_of = erf_pkg::ERF_RAM_DIGITS_SMALL;
         default: ram_limit_of = erf_pkg::ERF_RAM_DIGITS_FULL; // undefined code: full
      endcase
   endfunction

   function automatic logic [2:0] upper_mask_of(input logic [1:0] code);
      unique case (code)
         erf_pkg::ERF_SEL_FULL: upper_mask_of = erf_pkg::ERF_UPPER_MASK_FULL;
         erf_pkg::ERF_SEL_HALF: upper_mask_of = erf_pkg::ERF_UPPER_MASK_HALF;
         erf_pkg::ERF_SEL_SMALL: upper_mask_of = erf_pkg::ERF_UPPER_MASK_SMALL;
         default: upper_mask_of = erf_pkg::ERF_UPPER_MASK_FULL;
      endcase
   endfunction

   assign variant_code = {variant_select_high, variant_select_low};
   assign small_variant = (variant_code == erf_pkg::ERF_SEL_SMALL);

   // configuration outputs straight from the straps
   assign ram_digit_limit = ram_limit_of(variant_code);
   assign upper_address_mask = upper_mask_of(variant_code);
   assign stack_levels = small_variant ? erf_pkg::ERF_STACK_SMALL
                                       : erf_pkg::ERF_STACK_FULL;
   // active-low straps; smallest variant lacks these features entirely
   assign host_bus_enable = ~host_bus_select & ~small_variant;
   assign dual_clock_enable = ~dual_clock_select & ~small_variant;
   assign timer_enable = ~small_variant;
   assign interrupt_enable = ~small_variant;

   // ----------------------------------------
   // divide by four and fetch sequencing
   // ----------------------------------------
   // phase 0..3 is one divided clock; a fetch spans two of them
   always_comb begin
      state_next = state_reg;
      state_next.valid = 1'b0;
      state_next.phase = state_reg.phase + 2'h1;
      state_next.general_value = clock_pin_general_input;
      state_next.halt_drive = halt_request;
      state_next.l_oe = l_port_enable;
      state_next.l_data = l_port_data;
      if (state_reg.phase == erf_pkg::ERF_PHASE_LAST) begin
         unique case (state_reg.fetch)
            erf_pkg::ERF_ADDR: begin
               // address was latched as the last data phase ended; held so pins stay steady
               state_next.fetch = erf_pkg::ERF_DATA;
            end
            erf_pkg::ERF_DATA: begin
               // sample at end of data phase, after memory has settled
               state_next.instr = fetch_bus_in;
               state_next.valid = 1'b1;
               state_next.skip = skip_active;
               state_next.address = program_counter;
               state_next.fetch = erf_pkg::ERF_ADDR;
            end
         endcase
      end
   end

   // no power-on init: only the reset pin sets state
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         state_reg <= '{erf_pkg::ERF_PHASE_RESET, erf_pkg::ERF_ADDR, erf_pkg::ERF_PC_RESET,
                        erf_pkg::ERF_BYTE_RESET, 1'b0, 1'b0, erf_pkg::ERF_BYTE_RESET,
                        1'b0, 1'b0, 1'b0};
      end else begin
         state_reg <= state_next;
      end
   end

   // ----------------------------------------
   // pins
   // ----------------------------------------
   assign addr_phase_strobe = (state_reg.fetch == erf_pkg::ERF_ADDR);
   // drive only in the address phase so the memory can own the bus after
   assign fetch_bus_oe = addr_phase_strobe;
   assign fetch_bus_out = state_reg.address[7:0];
   // full width always driven; board grounds unused memory inputs
   assign upper_rom_address = state_reg.address[10:8];
   assign skip_out = state_reg.skip;
   assign instruction_byte = state_reg.instr;
   assign instruction_valid = state_reg.valid;
   assign cycle_tick = (state_reg.phase == erf_pkg::ERF_PHASE_LAST);
   assign clock_pin_general_value = state_reg.general_value;
   assign clock_pin_halt_out = 1'b0;
   assign clock_pin_halt_oe = state_reg.halt_drive;
   assign l_port_out = state_reg.l_data;
   assign l_port_oe = state_reg.l_oe;

   // ----------------------------------------
   // timer
   // ----------------------------------------
   erf_timer timer_inst (
      .sys_clk(sys_clk),
      .rst(rst),
      .time_base_tick(cycle_tick),
      .event_in(timer_event_in),
      .timer_source_select(timer_source_select),
      .timer_enable(timer_enable),
      .timer_count(timer_count),
      .timer_overflow(timer_overflow)
   );
endmodule

// ==== verilog/erf_pkg.sv ====
// Purpose: shared constants for the external program fetch and variant select block
// Assumes: sys_clk at 250 MHz, straps static while running
// Notes: variant codes are {variant_select_high, variant_select_low}
package erf_pkg;
   // ----------------------------------------
   // address space
   // ----------------------------------------
   localparam int ERF_PC_WIDTH = 11;
   localparam int ERF_LOW_WIDTH = 8;
   localparam int ERF_UPPER_WIDTH = 3;
   localparam int ERF_UPPER_LSB = 8;
   // ----------------------------------------
   // timing
   // ----------------------------------------
   localparam int ERF_CLOCK_DIVIDE = 4;
   localparam logic [1:0] ERF_PHASE_RESET = 2'h0;
   localparam logic [1:0] ERF_PHASE_LAST = 2'h3;
   // ----------------------------------------
   // variant straps and sizes
   // ----------------------------------------
   localparam logic [1:0] ERF_SEL_FULL = 2'h3;
   localparam logic [1:0] ERF_SEL_HALF = 2'h1;
   localparam logic [1:0] ERF_SEL_SMALL = 2'h0;
   localparam logic [6:0] ERF_RAM_DIGITS_FULL = 7'h7F;
   localparam logic [6:0] ERF_RAM_DIGITS_HALF = 7'h3F;
   localparam logic [6:0] ERF_RAM_DIGITS_SMALL = 7'h1F;
   localparam logic [1:0] ERF_STACK_FULL = 2'h3;
   localparam logic [1:0] ERF_STACK_SMALL = 2'h2;
   localparam logic [2:0] ERF_UPPER_MASK_FULL = 3'h7;
   localparam logic [2:0] ERF_UPPER_MASK_HALF = 3'h3;
   localparam logic [2:0] ERF_UPPER_MASK_SMALL = 3'h1;
   localparam logic [7:0] ERF_TIMER_RESET = 8'h00;
   localparam logic [10:0] ERF_PC_RESET = 11'h000;
   localparam logic [7:0] ERF_BYTE_RESET = 8'h00;
   // fetch states
   typedef enum logic [1:0] {
      ERF_ADDR = 2'h0,
      ERF_DATA = 2'h1
   } erf_fetch_type;
endpackage

// ==== verilog/erf_timer.sv ====
// Purpose: 8-bit timer with internal or external count source
// Assumes: event input already synchronous to sys_clk
// Notes: overflow is a one-cycle pulse
`timescale 1ns/1ps
module erf_timer (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic time_base_tick,
   input wire logic event_in,
   input wire logic timer_source_select,
   input wire logic timer_enable,
   output logic [7:0] timer_count,
   output logic timer_overflow
);
   typedef struct packed {
      logic [7:0] count;
      logic event_last;
      logic overflow;
   } erf_timer_state_type;
   erf_timer_state_type state_reg;
   erf_timer_state_type state_next;
   logic step;

   // ----------------------------------------
   // count source and next state
   // ----------------------------------------
   always_comb begin
      state_next = state_reg;
      state_next.event_last = event_in;
      state_next.overflow = 1'b0;
      // low strap: internal base; high: rising edge of the event pin
      step = timer_source_select ? (event_in & ~state_reg.event_last)
                                 : time_base_tick;
      if (timer_enable && step) begin
         state_next.count = state_reg.count + 8'h01;
         state_next.overflow = (state_reg.count == 8'hFF);
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         state_reg <= '{erf_pkg::ERF_TIMER_RESET, 1'b0, 1'b0};
      end else begin
         state_reg <= state_next;
      end
   end

   assign timer_count = state_reg.count;
   assign timer_overflow = state_reg.overflow;
endmodule
